/* rtl/fspg_guard.v */
// flash self-program guard: section checks, locks, stall and busy
// ==========================================
`timescale 1ns/1ps
`default_nettype none
`include "fspg_defines.vh"
module fspg_guard #(
  parameter AW = 17,
  parameter CRR_LIMIT = 17'h1e000,
  parameter PROG_CYCLES = (`FSPG_PROG_TIME_NS + `FSPG_CLK_NS - 1) /
    `FSPG_CLK_NS
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire [1:0] i_boot_size_fuses,
  input wire [1:0] i_general_lock,
  input wire [3:0] i_port_lock_value,
  input wire i_port_lock_write,
  input wire i_chip_erase,
  input wire [AW-1:0] i_pc,
  input wire [AW-1:0] i_fetch_addr,
  input wire i_load_req,
  input wire [AW-1:0] i_load_addr,
  output reg o_core_stall,
  output reg o_flash_erase,
  output reg o_flash_write,
  output reg [AW-1:0] o_flash_page_addr,
  output reg o_load_allowed,
  output reg o_fetch_blocked,
  output reg o_app_vector_mask,
  output reg o_boot_vector_mask
);
  // ==========================================
  // state
  localparam ST_IDLE = 3'b001;
  localparam ST_CONC = 3'b010;
  localparam ST_HALT = 3'b100;
  localparam [2:0] ARM_INIT = `FSPG_ARM_CYCLES;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [4:0] ctrl;
  reg [3:0] lock;
  reg [AW-1:0] target;
  reg cr_busy;
  reg refused;
  reg [2:0] arm_cnt;
  reg [15:0] prog_cnt;
  wire pc_boot;
  wire pc_stall;
  wire tgt_boot;
  wire tgt_stall;
  wire ld_boot;
  wire ld_stall;
  wire fe_boot;
  wire fe_stall;

  // ==========================================
  // classification of each address of interest
  fspg_region #(.AW(AW), .CRR_LIMIT(CRR_LIMIT)) u_pc (
    .i_addr(i_pc), .i_boot_size_fuses(i_boot_size_fuses),
    .o_in_boot(pc_boot), .o_in_stalling(pc_stall));
  fspg_region #(.AW(AW), .CRR_LIMIT(CRR_LIMIT)) u_tgt (
    .i_addr(target), .i_boot_size_fuses(i_boot_size_fuses),
    .o_in_boot(tgt_boot), .o_in_stalling(tgt_stall));
  fspg_region #(.AW(AW), .CRR_LIMIT(CRR_LIMIT)) u_ld (
    .i_addr(i_load_addr), .i_boot_size_fuses(i_boot_size_fuses),
    .o_in_boot(ld_boot), .o_in_stalling(ld_stall));
  fspg_region #(.AW(AW), .CRR_LIMIT(CRR_LIMIT)) u_fe (
    .i_addr(i_fetch_addr), .i_boot_size_fuses(i_boot_size_fuses),
    .o_in_boot(fe_boot), .o_in_stalling(fe_stall));

  // ==========================================
  // lock decode helpers; a pair is {high, low}
  function write_locked;
    input [1:0] pair;
    begin
      write_locked = (pair == 2'b10) || (pair == 2'b00);
    end
  endfunction
  function load_locked;
    input [1:0] pair;
    begin
      load_locked = (pair == 2'b00) || (pair == 2'b01);
    end
  endfunction

  wire [1:0] app_pair;
  wire [1:0] boot_pair;
  assign app_pair = {lock[`FSPG_LOCK_APP_HIGH], lock[`FSPG_LOCK_APP_LOW]};
  assign boot_pair = {lock[`FSPG_LOCK_BOOT_HIGH], lock[`FSPG_LOCK_BOOT_LOW]};

  // ==========================================
  // store decision; general lock is deliberately not consulted
  wire cmd_store;
  wire cmd_load;
  wire armed;
  wire store_ok;
  wire sect_locked;
  assign cmd_store = i_wr && (i_addr == `FSPG_OFF_CMD) &&
    (i_wdata[1:0] == `FSPG_CMD_STORE);
  assign cmd_load = i_wr && (i_addr == `FSPG_OFF_CMD) &&
    (i_wdata[1:0] == `FSPG_CMD_LOAD);
  assign armed = ctrl[`FSPG_CTRL_SPE] && (arm_cnt != 3'h0);
  // each pair guards its own section only
  assign sect_locked = tgt_boot ? write_locked(boot_pair) :
    write_locked(app_pair);
  assign store_ok = cmd_store && armed && pc_boot &&
    (state == ST_IDLE) && !sect_locked;
  wire do_prog;
  wire do_lockset;
  wire do_rre;
  assign do_prog = store_ok &&
    (ctrl[`FSPG_CTRL_PGERS] || ctrl[`FSPG_CTRL_PGWRT]);
  assign do_lockset = cmd_store && armed && pc_boot &&
    ctrl[`FSPG_CTRL_BLBSET] && (state == ST_IDLE);
  assign do_rre = cmd_store && armed && pc_boot &&
    ctrl[`FSPG_CTRL_RRE] && (state == ST_IDLE);

  // ==========================================
  // sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (do_prog) begin
          next_state = tgt_stall ? ST_HALT : ST_CONC;
        end
      end
      ST_CONC, ST_HALT: begin
        if (prog_cnt == 16'h0001) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      ctrl <= 5'h00;
      target <= {AW{1'b0}};
      arm_cnt <= 3'h0;
      prog_cnt <= 16'h0000;
      cr_busy <= 1'b0;
      refused <= 1'b0;
      o_rdata <= 8'h00;
      o_core_stall <= 1'b0;
      o_flash_erase <= 1'b0;
      o_flash_write <= 1'b0;
      o_flash_page_addr <= {AW{1'b0}};
      o_load_allowed <= 1'b0;
      o_fetch_blocked <= 1'b0;
      o_app_vector_mask <= 1'b0;
      o_boot_vector_mask <= 1'b0;
    end else begin
      state <= next_state;
      // control register; enable window lasts a few cycles
      if (i_wr && i_addr == `FSPG_OFF_CTRL && state == ST_IDLE) begin
        ctrl <= i_wdata[4:0];
        arm_cnt <= ARM_INIT;
      end else if (arm_cnt != 3'h0) begin
        arm_cnt <= arm_cnt - 3'h1;
      end else if (state == ST_IDLE) begin
        ctrl <= 5'h00;
      end
      if (i_wr && i_addr == `FSPG_OFF_ADDR) begin
        target <= {i_wdata, {(AW-8){1'b0}}};
      end
      if (cmd_store) begin
        arm_cnt <= 3'h0;
      end
      if (do_prog) begin
        prog_cnt <= PROG_CYCLES[15:0];
        o_flash_page_addr <= target;
        o_flash_erase <= ctrl[`FSPG_CTRL_PGERS];
        o_flash_write <= ctrl[`FSPG_CTRL_PGWRT] && !ctrl[`FSPG_CTRL_PGERS];
      end else if (prog_cnt != 16'h0000) begin
        prog_cnt <= prog_cnt - 16'h0001;
        if (prog_cnt == 16'h0001) begin
          o_flash_erase <= 1'b0;
          o_flash_write <= 1'b0;
          ctrl <= 5'h00;
        end
      end
      // refused store stays visible until the next control write
      if (cmd_store && !store_ok && !do_lockset && !do_rre) begin
        refused <= 1'b1;
      end else if (i_wr && i_addr == `FSPG_OFF_CTRL) begin
        refused <= 1'b0;
      end
      // busy: start on a non-stalling page sets; enable after completion or page load clears
      if (do_prog && !tgt_stall) begin
        cr_busy <= 1'b1;
      end else if (do_rre || (cmd_load && state == ST_IDLE)) begin
        cr_busy <= 1'b0;
      end
      o_core_stall <= (next_state == ST_HALT);
      o_fetch_blocked <= (next_state == ST_HALT) ||
        ((cr_busy || (do_prog && !tgt_stall)) && !fe_stall);
      // loads obey the section locks, the busy region and the stall
      o_load_allowed <= i_load_req && (next_state != ST_HALT) &&
        !(cr_busy && !ld_stall) &&
        !(ld_boot && !pc_boot && load_locked(boot_pair)) &&
        !(!ld_boot && pc_boot && load_locked(app_pair));
      o_app_vector_mask <= pc_boot && load_locked(app_pair);
      o_boot_vector_mask <= pc_boot && load_locked(boot_pair);
      if (i_rd) begin
        case (i_addr)
          `FSPG_OFF_CTRL: o_rdata <= {3'h0, ctrl};
          `FSPG_OFF_LOCK: o_rdata <= {4'h0, lock};
          `FSPG_OFF_STAT: o_rdata <= {4'h0, state == ST_HALT, refused,
            cr_busy, state != ST_IDLE};
          `FSPG_OFF_ADDR: o_rdata <= target[AW-1:AW-8];
          default: o_rdata <= 8'h00;
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // ==========================================
  // lock bits: programming only moves 1 to 0, chip erase restores
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      lock <= `FSPG_LOCK_RESET;
    end else if (i_chip_erase) begin
      lock <= `FSPG_LOCK_RESET;
    end else if (i_port_lock_write) begin
      lock <= lock & i_port_lock_value;
    end else if (do_lockset) begin
      lock <= lock & i_wdata[7:4];
    end
  end

  // general lock and fe_boot do not enter any decision above
  wire unused_ok;
  assign unused_ok = &{1'b0, i_general_lock, fe_boot};
endmodule // fspg_guard
`default_nettype wire

/* rtl/fspg_defines.vh */
// constants for the flash self-program guard
`ifndef FSPG_DEFINES_VH
`define FSPG_DEFINES_VH
// ==========================================
// register offsets (word index on the plain port)
`define FSPG_OFF_CTRL 4'h0
`define FSPG_OFF_LOCK 4'h1
`define FSPG_OFF_STAT 4'h2
`define FSPG_OFF_CMD 4'h3
`define FSPG_OFF_ADDR 4'h4
// ==========================================
// control register fields
`define FSPG_CTRL_SPE 0
`define FSPG_CTRL_PGERS 1
`define FSPG_CTRL_PGWRT 2
`define FSPG_CTRL_BLBSET 3
`define FSPG_CTRL_RRE 4
// ==========================================
// lock register fields (1 = unprogrammed)
`define FSPG_LOCK_APP_LOW 0
`define FSPG_LOCK_APP_HIGH 1
`define FSPG_LOCK_BOOT_LOW 2
`define FSPG_LOCK_BOOT_HIGH 3
`define FSPG_LOCK_RESET 4'hf
// ==========================================
// status register fields
`define FSPG_STAT_BUSY 0
`define FSPG_STAT_CRBUSY 1
`define FSPG_STAT_REFUSED 2
`define FSPG_STAT_STALL 3
// ==========================================
// command codes on the command register
`define FSPG_CMD_STORE 2'h1
`define FSPG_CMD_LOAD 2'h2
`define FSPG_CMD_CHIP_ERASE 2'h3
// ==========================================
// timing
`define FSPG_PROG_TIME_NS 4000
`define FSPG_CLK_NS 4
`define FSPG_ARM_CYCLES 4
`endif

/* rtl/fspg_region.v */
// section and region classifier for one flash address
`timescale 1ns/1ps
`default_nettype none
module fspg_region #(
  parameter AW = 17,
  parameter CRR_LIMIT = 17'h1e000
) (
  input wire [AW-1:0] i_addr,
  input wire [1:0] i_boot_size_fuses,
  output reg o_in_boot,
  output reg o_in_stalling
);
  // ==========================================
  // boot section size from fuses, always at the top of flash
  reg [AW-1:0] boot_start;
  always @* begin
    case (i_boot_size_fuses)
      2'h3: boot_start = CRR_LIMIT + 17'h1c00;
      2'h2: boot_start = CRR_LIMIT + 17'h1800;
      2'h1: boot_start = CRR_LIMIT + 17'h1000;
      default: boot_start = CRR_LIMIT;
    endcase
    // boot never reaches below the fixed limit
    if (boot_start < CRR_LIMIT) begin
      boot_start = CRR_LIMIT;
    end
    o_in_boot = (i_addr >= boot_start);
    o_in_stalling = (i_addr >= CRR_LIMIT);
  end
endmodule // fspg_region
`default_nettype wire

/* verif/fspg_guard_monitor.sv */
// port checker for the flash self-program guard
`timescale 1ns/1ps
`default_nettype none
module fspg_guard_monitor #(
  parameter AW = 17,
  parameter CRR_LIMIT = 17'h1e000
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_chip_erase,
  input wire [AW-1:0] i_pc,
  input wire o_core_stall,
  input wire o_flash_erase,
  input wire o_flash_write,
  input wire [AW-1:0] o_flash_page_addr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire prog = o_flash_erase | o_flash_write;
  // ==========================================
  // assertions
  chk_stall_needs_op: assert property (o_core_stall |-> prog)
    else $error("stall without page operation");
  chk_stall_region: assert property (
    o_core_stall |-> o_flash_page_addr >= CRR_LIMIT)
    else $error("stall for concurrent page");
  chk_conc_runs: assert property (
    prog && o_flash_page_addr < CRR_LIMIT |-> !o_core_stall)
    else $error("core halted on concurrent page");
  // span matches the shortened bench count of 8
  chk_stall_whole: assert property (
    $rose(o_core_stall) |-> o_core_stall [*8])
    else $error("stall dropped early");
  chk_stall_release: assert property ($fell(o_core_stall) |-> !prog)
    else $error("stall released mid operation");
  chk_app_store_void: assert property (
    i_wr && i_addr == 4'h3 && i_wdata[1:0] == 2'h1 &&
    i_pc < CRR_LIMIT |=> !$rose(prog))
    else $error("store from application programmed");
  chk_one_op: assert property (!(o_flash_erase && o_flash_write))
    else $error("erase and write together");
  chk_lock_erased: assert property (
    i_chip_erase ##1 (i_rd && i_addr == 4'h1) |=> o_rdata[3:0] == 4'hf)
    else $error("lock not cleared by chip erase");
  cover property ($rose(o_core_stall));
  cover property ($rose(prog) && !o_core_stall);
  cover property ($rose(o_flash_write));
endmodule // fspg_guard_monitor
bind fspg_guard fspg_guard_monitor #(.AW(AW), .CRR_LIMIT(CRR_LIMIT)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_chip_erase(i_chip_erase),
  .i_pc(i_pc), .o_core_stall(o_core_stall), .o_flash_erase(o_flash_erase),
  .o_flash_write(o_flash_write), .o_flash_page_addr(o_flash_page_addr));
`default_nettype wire

/* verif/fspg_core_model.sv */
// core model running the boot loader
`timescale 1ns/1ps
`default_nettype none
module fspg_core_model (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [16:0] i_goto,
  input wire i_load_go,
  input wire [16:0] i_load_at,
  input wire i_stall,
  output reg [16:0] o_pc,
  output reg [16:0] o_fetch,
  output reg o_load_req,
  output reg [16:0] o_load_addr
);
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pc <= 17'h00000;
      o_fetch <= 17'h00000;
      o_load_req <= 1'b0;
      o_load_addr <= 17'h00000;
    end else begin
      // a halted core neither moves nor fetches
      if (!i_stall) begin
        o_pc <= i_goto;
        o_fetch <= i_goto;
      end
      o_load_req <= i_load_go;
      // idle address lines do not keep the last value
      o_load_addr <= i_load_go ? i_load_at : ~o_load_addr;
    end
  end
endmodule // fspg_core_model
`default_nettype wire

/* verif/test_flash_self_program_guard.sv */
// testbench for the flash self-program guard
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks = total_checks + 1; \
  if ((a) !== (b)) begin miscompares = miscompares + 1; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module test_flash_self_program_guard;
  reg clk = 0, rst = 1, wr = 0, rd = 0, plw = 0, cer = 0, lgo = 0;
  reg [3:0] addr = 4'h0, plv = 4'hf;
  reg [7:0] wdata = 8'h00, d;
  reg [1:0] fuses = 2'h0, gl = 2'h3;
  reg [16:0] go = 17'h1ff00, lat = 17'h00000;
  reg op, stl, fb;
  wire [7:0] rdata;
  wire stall, ers, wrt, lreq, ldok, fblk, avm, bvm;
  wire [16:0] pa, pc, fa, laddr;
  integer miscompares = 0, total_checks = 0, i;
  fspg_core_model u_core (.i_sys_clk(clk), .i_rst(rst), .i_goto(go),
    .i_load_go(lgo), .i_load_at(lat), .i_stall(stall), .o_pc(pc),
    .o_fetch(fa), .o_load_req(lreq), .o_load_addr(laddr));
  fspg_guard #(.PROG_CYCLES(8)) u_dut (.i_sys_clk(clk), .i_rst(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_boot_size_fuses(fuses), .i_general_lock(gl),
    .i_port_lock_value(plv), .i_port_lock_write(plw), .i_chip_erase(cer),
    .i_pc(pc), .i_fetch_addr(fa), .i_load_req(lreq), .i_load_addr(laddr),
    .o_core_stall(stall), .o_flash_erase(ers), .o_flash_write(wrt),
    .o_flash_page_addr(pa), .o_load_allowed(ldok), .o_fetch_blocked(fblk),
    .o_app_vector_mask(avm), .o_boot_vector_mask(bvm));
  initial forever #2 clk = ~clk;
  // ==========================================
  // bus and core tasks
  task wrr(input [3:0] a, input [7:0] v); begin
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  end endtask
  task rdr(input [3:0] a); begin
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
  end endtask
  task jump(input [16:0] a, input [1:0] f); begin
    @(posedge clk); go <= a; fuses <= f;
    repeat (3) @(posedge clk);
  end endtask
  task store(input [7:0] page, input [7:0] ctl, input [7:0] cmd); begin
    wrr(4'h4, page); wrr(4'h0, ctl); wrr(4'h3, cmd);
    op = 0; stl = 0;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk); #1;
      if ((ers | wrt) === 1'b1 && !op) begin
        op = 1;
        stl = stall;
        fb = fblk;
      end
    end
    for (i = 0; i < 20 && (ers | wrt) !== 1'b0; i = i + 1) @(posedge clk);
  end endtask
  task pulse_lock(input [3:0] v, input e); begin
    @(posedge clk); plv <= v; plw <= !e; cer <= e;
    @(posedge clk); plw <= 1'b0; cer <= 1'b0;
  end endtask
  task load(input [16:0] a); begin
    @(posedge clk); lat <= a; lgo <= 1'b1;
    @(posedge clk); lgo <= 1'b0;
    @(posedge clk); #1;
  end endtask
  // ==========================================
  // scenarios
  task t_conc; begin
    rdr(4'h1); `CHK(d[3:0], 4'hf)
    store(8'h01, 8'h03, 8'h01); `CHK(op, 1'b1)
    `CHK(stl, 1'b0)
    `CHK(fb, 1'b0)
    `CHK(pa, 17'h00200)
    rdr(4'h2); `CHK(d[1], 1'b1)
    store(8'h01, 8'h11, 8'h01); rdr(4'h2); `CHK(d[1], 1'b0)
    store(8'h01, 8'h05, 8'h01); `CHK(op, 1'b1)
    store(8'h01, 8'h01, 8'h02); rdr(4'h2); `CHK(d[1], 1'b0)
  end endtask
  task t_stall; begin
    gl <= 2'h0;
    store(8'hff, 8'h05, 8'h01); `CHK(stl, 1'b1)
    `CHK(fb, 1'b1)
    `CHK(pa, 17'h1fe00)
    store(8'hf0, 8'h03, 8'h01); `CHK(stl, 1'b1)
    load(17'h00100); `CHK(ldok, 1'b1)
    gl <= 2'h3;
  end endtask
  task t_sections; begin
    jump(17'h00100, 2'h0);
    store(8'h01, 8'h03, 8'h01); `CHK(op, 1'b0)
    rdr(4'h2); `CHK(d[2], 1'b1)
    jump(17'h1e100, 2'h3);
    store(8'hff, 8'h03, 8'h01); `CHK(op, 1'b0)
    jump(17'h1fd00, 2'h3);
    store(8'hff, 8'h03, 8'h01); `CHK(op, 1'b1)
    jump(17'h1ff00, 2'h0);
  end endtask
  task t_locks; begin
    store(8'h00, 8'h09, 8'he1); rdr(4'h1); `CHK(d[3:0], 4'he)
    store(8'h01, 8'h03, 8'h01); `CHK(op, 1'b0)
    store(8'hff, 8'h03, 8'h01); `CHK(op, 1'b1)
    pulse_lock(4'hf, 1'b1); rdr(4'h1); `CHK(d[3:0], 4'hf)
    pulse_lock(4'hb, 1'b0); rdr(4'h1); `CHK(d[3:0], 4'hb)
    store(8'hff, 8'h03, 8'h01); `CHK(op, 1'b0)
    store(8'h01, 8'h03, 8'h01); `CHK(op, 1'b1)
    store(8'h01, 8'h11, 8'h01);
    pulse_lock(4'hc, 1'b0); load(17'h00100); `CHK(ldok, 1'b0)
    `CHK(avm, 1'b1)
    `CHK(bvm, 1'b0)
    pulse_lock(4'hf, 1'b1);
  end endtask
  task conclude; begin
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  end endtask
  initial begin
    #40000;
    miscompares = miscompares + 1;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_conc;
    t_stall;
    t_sections;
    t_locks;
    conclude;
  end
endmodule // test_flash_self_program_guard
`default_nettype wire
